// file: core/limit_timer.sv
// Time-limit timer: per ms tick, integrates current multiple (long inverse) or counts ticks (fixed delay) toward the curve limit.
// Assumes tick is a one-cycle pulse every millisecond.
`timescale 1ns/1ns
module limit_timer (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   tick,
  input  wire logic                   run,
  input  wire logic                   clear,
  input  wire startup_oc_pkg::curve_t curve,
  input  wire logic [7:0]             koct,
  input  wire logic [15:0]            rated,
  input  wire logic [15:0]            current,
  output logic                        done
);
  logic [39:0] acc_r;
  logic [39:0] limit;
  logic [39:0] step;

  // Summing current for t ms against 3000*K*rated equals t = 3000*K/(current/rated)
  always_comb begin
    if (curve == startup_oc_pkg::long_inverse_curve) begin
      limit = 40'(startup_oc_pkg::INV_MS_PER_K * koct * rated); // RULE11 RULE13
      step  = {24'h00_0000, current};
    end else begin
      limit = 40'(startup_oc_pkg::FIX_MS_PER_K * koct); // RULE12
      step  = 40'h00_0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 40'h00_0000_0000;
    end else if (clear) begin
      acc_r <= 40'h00_0000_0000;
    end else if (tick && run && acc_r < limit) begin
      acc_r <= acc_r + step; // RULE4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= !clear && (acc_r >= limit) && (limit != 40'h00_0000_0000);
    end
  end
endmodule

// file: core/mean_divider.sv
// Serial restoring divider giving the mean current of an averaging window.
// Assumes start is a pulse given only while busy is low.
`timescale 1ns/1ns
module mean_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  output logic             busy,
  output logic [15:0]      quotient
);
  logic [5:0]  cnt_r;
  logic [31:0] quo_r;
  logic [16:0] rem_r;
  logic [15:0] div_r;
  logic [16:0] trial;

  assign trial = {rem_r[15:0], quo_r[31]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy  <= 1'b0;
      cnt_r <= 6'h00;
      quo_r <= 32'h0000_0000;
      rem_r <= 17'h0_0000;
      div_r <= 16'h0000;
    end else if (start) begin
      busy  <= 1'b1;
      cnt_r <= 6'h00;
      quo_r <= dividend;
      rem_r <= 17'h0_0000;
      div_r <= divisor;
    end else if (busy) begin
      if (trial >= {1'b0, div_r}) begin
        rem_r <= trial - {1'b0, div_r};
        quo_r <= {quo_r[30:0], 1'b1};
      end else begin
        rem_r <= trial;
        quo_r <= {quo_r[30:0], 1'b0};
      end
      cnt_r <= cnt_r + 6'h01;
      busy  <= (cnt_r != 6'h1f);
    end
  end

  // Empty window gives zero; overflow saturates to 16'hffff rather than wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quotient <= 16'h0000;
    end else if (busy && cnt_r == 6'h1f) begin
      if (div_r == 16'h0000) begin
        quotient <= 16'h0000;
      end else if (quo_r[30:15] != 16'h0000) begin
        quotient <= 16'hffff;
      end else begin
        quotient <= {quo_r[14:0], (trial >= {1'b0, div_r})};
      end
    end
  end
endmodule

// file: core/startup_oc_pkg.sv
// Constants, register map and types for the startup overcurrent element.
// Assumes a 125 MHz pclk and a 32-bit APB slave port.
package startup_oc_pkg;
  localparam int unsigned PCLK_NS     = 8;
  localparam int unsigned TICK_NS     = 1_000_000;
  localparam int unsigned TICK_CYCLES = TICK_NS / PCLK_NS;
  localparam int unsigned RESET_MS    = 200;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_PICKUP = 12'h004;
  localparam logic [11:0] ADDR_KOCT   = 12'h008;
  localparam logic [11:0] ADDR_RATED  = 12'h00c;
  localparam logic [11:0] ADDR_AVGCYC = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_MASK   = 12'h018;
  localparam logic [11:0] ADDR_STATE  = 12'h01c;

  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_AVG_BIT   = 1;
  localparam int unsigned CTRL_CURVE_BIT = 2;
  localparam int unsigned CTRL_STD_BIT   = 3;
  localparam int unsigned CTRL_W         = 4;

  localparam int unsigned EV_START_BIT = 0;
  localparam int unsigned EV_PICK_BIT  = 1;
  localparam int unsigned EV_TRIP_BIT  = 2;
  localparam int unsigned EV_W         = 3;

  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
  localparam logic [10:0]       PICKUP_RST = 11'h0c8;
  localparam logic [10:0]       PICKUP_MIN = 11'h0c8;
  localparam logic [10:0]       PICKUP_MAX = 11'h7d0;
  localparam logic [7:0]        KOCT_RST   = 8'h04;
  localparam logic [7:0]        KOCT_MIN   = 8'h04;
  localparam logic [7:0]        KOCT_MAX   = 8'hf0;
  localparam logic [15:0]       RATED_RST  = 16'h0064;
  localparam logic [7:0]        AVGCYC_RST = 8'h01;
  localparam logic [EV_W-1:0]   MASK_RST   = 3'h0;

  localparam logic [11:0] INV_MS_PER_K = 12'hbb8;
  localparam logic [7:0]  FIX_MS_PER_K = 8'hc8;
  localparam logic [6:0]  PCT_SCALE   = 7'h64;
  localparam logic [4:0]  STD_NUM     = 5'h17;
  localparam logic [4:0]  STD_DEN     = 5'h14;

  typedef enum logic {long_inverse_curve, fixed_delay_curve} curve_t;
endpackage

// file: core/startup_overcurrent_element.sv
// Startup overcurrent element with APB registers, averaging and trip output.
// Assumes current samples and breaker input synchronous to pclk.
//
// Function
// [RULE1] Element works only while the breaker status input is low.
// [RULE2] Detection needs pickup true and the time-limit timer completed.
// [RULE3] Pickup when current exceeds setting, or 1.15 times it in standards mode.
// [RULE4] Timer advances per curve while current exceeds the operating setting.
// [RULE5] A 200 ms reset timer keeps the output from chattering.
// [RULE6] Trip output only appears while the element is enabled.
// [RULE7] With averaging on, current is the mean over set rotation cycles.
// [RULE8] Operating current setting 200 to 2000 percent, 2 percent steps.
// [RULE9] Time multiplier setting 4 to 240 in unit steps.
// [RULE10] Curve select chooses long inverse or fixed delay only.
// [RULE11] Long inverse time is 3 times multiplier over current multiple.
// [RULE12] Fixed delay time is 2 times multiplier over ten.
// [RULE13] Current multiple is measured current over rated motor current.
// [RULE14] Standards mode changes nothing above 1.15 times pickup.
// [RULE15] Timer and detection clear only after 200 ms below threshold.
`timescale 1ns/1ns
module startup_overcurrent_element #(
  parameter int unsigned TICK_CYCLES = startup_oc_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] line_current,
  input  wire logic        current_valid,
  input  wire logic        rotation_mark,
  input  wire logic        breaker_status_input,
  output logic             trip_out,
  output logic             irq
);
  typedef enum logic [1:0] {st_off, st_watch, st_pick, st_drop} elem_state_t;

  logic [startup_oc_pkg::CTRL_W-1:0] ctrl_r;
  logic [10:0]                       pickup_r;
  logic [7:0]                        koct_r;
  logic [15:0]                       rated_r;
  logic [7:0]                        avgcyc_r;
  logic [startup_oc_pkg::EV_W-1:0]   status_r;
  logic [startup_oc_pkg::EV_W-1:0]   mask_r;
  logic [startup_oc_pkg::EV_W-1:0]   status_nxt;
  logic [startup_oc_pkg::EV_W-1:0]   events;

  logic                              access;
  logic                              xfer_done;
  logic                              wr_en;
  logic                              mapped;
  logic [31:0]                       rd_mux;

  logic [16:0]                       tick_cnt_r;
  logic                              tick_r;

  logic [15:0]                       sample_r;
  logic [31:0]                       sum_r;
  logic [15:0]                       nsamp_r;
  logic [7:0]                        cyc_r;
  logic                              div_start_r;
  logic                              div_busy;
  logic [15:0]                       avg_cur;
  logic [15:0]                       elem_cur;

  logic                              active;
  logic                              active_d_r;
  logic [33:0]                       cur_scaled;
  logic [33:0]                       set_scaled;
  logic                              pickup;
  logic                              over_set;
  elem_state_t                       state_r;
  logic [7:0]                        rst_cnt_r;
  logic                              drop_expire;
  logic                              timer_clear;
  logic                              timer_done;
  logic                              detect;
  logic                              detect_d_r;
  startup_oc_pkg::curve_t            curve;

  // APB: one wait state, pready registered
  assign access    = psel && penable;
  assign xfer_done = access && pready;
  assign wr_en     = xfer_done && pwrite && !pslverr;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      startup_oc_pkg::ADDR_CTRL:   rd_mux = 32'(ctrl_r);
      startup_oc_pkg::ADDR_PICKUP: rd_mux = 32'(pickup_r);
      startup_oc_pkg::ADDR_KOCT:   rd_mux = 32'(koct_r);
      startup_oc_pkg::ADDR_RATED:  rd_mux = 32'(rated_r);
      startup_oc_pkg::ADDR_AVGCYC: rd_mux = 32'(avgcyc_r);
      startup_oc_pkg::ADDR_STATUS: rd_mux = 32'(status_r);
      startup_oc_pkg::ADDR_MASK:   rd_mux = 32'(mask_r);
      startup_oc_pkg::ADDR_STATE:  rd_mux = {9'h000, timer_done, pickup, active, state_r, 2'h0, elem_cur};
      default:                     mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Settings; out-of-range writes are clamped, not rejected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= startup_oc_pkg::CTRL_RST;
    end else if (wr_en && paddr == startup_oc_pkg::ADDR_CTRL) begin
      ctrl_r <= pwdata[startup_oc_pkg::CTRL_W-1:0]; // RULE10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pickup_r <= startup_oc_pkg::PICKUP_RST;
    end else if (wr_en && paddr == startup_oc_pkg::ADDR_PICKUP) begin
      if (pwdata[31:11] != 21'h0 || pwdata[10:0] > startup_oc_pkg::PICKUP_MAX) begin
        pickup_r <= startup_oc_pkg::PICKUP_MAX; // RULE8
      end else if (pwdata[10:0] < startup_oc_pkg::PICKUP_MIN) begin
        pickup_r <= startup_oc_pkg::PICKUP_MIN; // RULE8
      end else begin
        pickup_r <= {pwdata[10:1], 1'b0}; // RULE8
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      koct_r <= startup_oc_pkg::KOCT_RST;
    end else if (wr_en && paddr == startup_oc_pkg::ADDR_KOCT) begin
      if (pwdata[31:8] != 24'h0 || pwdata[7:0] > startup_oc_pkg::KOCT_MAX) begin
        koct_r <= startup_oc_pkg::KOCT_MAX; // RULE9
      end else if (pwdata[7:0] < startup_oc_pkg::KOCT_MIN) begin
        koct_r <= startup_oc_pkg::KOCT_MIN; // RULE9
      end else begin
        koct_r <= pwdata[7:0]; // RULE9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rated_r  <= startup_oc_pkg::RATED_RST;
      avgcyc_r <= startup_oc_pkg::AVGCYC_RST;
      mask_r   <= startup_oc_pkg::MASK_RST;
    end else if (wr_en) begin
      if (paddr == startup_oc_pkg::ADDR_RATED) begin
        rated_r <= pwdata[15:0];
      end
      if (paddr == startup_oc_pkg::ADDR_AVGCYC) begin
        avgcyc_r <= (pwdata[7:0] == 8'h00) ? startup_oc_pkg::AVGCYC_RST : pwdata[7:0];
      end
      if (paddr == startup_oc_pkg::ADDR_MASK) begin
        mask_r <= pwdata[startup_oc_pkg::EV_W-1:0];
      end
    end
  end

  // Millisecond tick for both timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 17'h0_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 17'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 17'h0_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h0_0001;
      tick_r     <= 1'b0;
    end
  end

  // Current capture and rotation-cycle averaging window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_r <= 16'h0000;
    end else if (current_valid) begin
      sample_r <= line_current;
    end
  end

  // A sample landing on the closing mark belongs to the window it closes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_r       <= 32'h0000_0000;
      nsamp_r     <= 16'h0000;
      cyc_r       <= 8'h00;
      div_start_r <= 1'b0;
    end else begin
      div_start_r <= 1'b0;
      if (rotation_mark && cyc_r + 8'h01 >= avgcyc_r && !div_busy && !div_start_r) begin
        div_start_r <= 1'b1; // RULE7
        cyc_r       <= 8'h00;
      end else if (rotation_mark && cyc_r != 8'hff) begin
        cyc_r <= cyc_r + 8'h01;
      end
      if (current_valid && nsamp_r != 16'hffff) begin
        sum_r   <= sum_r + 32'(line_current);
        nsamp_r <= nsamp_r + 16'h0001;
      end
      if (div_start_r) begin
        sum_r   <= current_valid ? 32'(line_current) : 32'h0000_0000;
        nsamp_r <= current_valid ? 16'h0001 : 16'h0000;
      end
    end
  end

  mean_divider u_mean (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (div_start_r),
    .dividend (sum_r),
    .divisor  (nsamp_r),
    .busy     (div_busy),
    .quotient (avg_cur)
  );

  assign elem_cur = ctrl_r[startup_oc_pkg::CTRL_AVG_BIT] ? avg_cur : sample_r; // RULE7

  // Breaker closed means motor energised: startup window is over
  assign active = !breaker_status_input; // RULE1

  // Scaled by 100*20 so both thresholds compare without division
  assign cur_scaled = 34'(elem_cur * startup_oc_pkg::PCT_SCALE * startup_oc_pkg::STD_DEN);
  assign set_scaled = 34'(pickup_r * rated_r * startup_oc_pkg::STD_DEN);

  always_comb begin
    if (ctrl_r[startup_oc_pkg::CTRL_STD_BIT]) begin
      pickup = cur_scaled > 34'(pickup_r * rated_r * startup_oc_pkg::STD_NUM); // RULE3
    end else begin
      pickup = cur_scaled > set_scaled; // RULE3
    end
  end

  assign over_set = active && (cur_scaled > set_scaled); // RULE4

  assign curve = ctrl_r[startup_oc_pkg::CTRL_CURVE_BIT] ? startup_oc_pkg::fixed_delay_curve
                                                        : startup_oc_pkg::long_inverse_curve; // RULE10

  // Timer ignores the standards option, so times match above 1.15x pickup
  limit_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_r),
    .run     (over_set),
    .clear   (timer_clear),
    .curve   (curve),
    .koct    (koct_r),
    .rated   (rated_r),
    .current (elem_cur),
    .done    (timer_done)
  ); // RULE14

  assign drop_expire = (state_r == st_drop) && tick_r &&
                       (rst_cnt_r == 8'(startup_oc_pkg::RESET_MS - 1)) && !pickup; // RULE5
  assign timer_clear = (state_r == st_off) || drop_expire; // RULE15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_off;
    end else if (!active) begin
      state_r <= st_off; // RULE1
    end else begin
      unique case (state_r)
        st_off: begin
          state_r <= st_watch;
        end
        st_watch: begin
          if (pickup) begin
            state_r <= st_pick;
          end
        end
        st_pick: begin
          if (!pickup) begin
            state_r <= st_drop;
          end
        end
        st_drop: begin
          if (pickup) begin
            state_r <= st_pick;
          end else if (drop_expire) begin
            state_r <= st_watch; // RULE15
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= 8'h00;
    end else if (state_r != st_drop || pickup) begin
      rst_cnt_r <= 8'h00;
    end else if (tick_r) begin
      rst_cnt_r <= rst_cnt_r + 8'h01; // RULE5
    end
  end

  // Drop state holds detection through the reset interval
  assign detect = timer_done && (state_r == st_pick || state_r == st_drop); // RULE2 RULE15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_out <= 1'b0;
    end else begin
      trip_out <= detect && ctrl_r[startup_oc_pkg::CTRL_EN_BIT]; // RULE6
    end
  end

  // Events, sticky status cleared by read; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Starts as active, so an open breaker at reset is no false start event
      active_d_r <= 1'b1;
      detect_d_r <= 1'b0;
    end else begin
      active_d_r <= active;
      detect_d_r <= detect && ctrl_r[startup_oc_pkg::CTRL_EN_BIT];
    end
  end

  always_comb begin
    events = '0;
    events[startup_oc_pkg::EV_START_BIT] = active && !active_d_r;
    events[startup_oc_pkg::EV_PICK_BIT]  = (state_r == st_watch) && active && pickup;
    events[startup_oc_pkg::EV_TRIP_BIT]  = detect && ctrl_r[startup_oc_pkg::CTRL_EN_BIT] && !detect_d_r;
    if (xfer_done && !pwrite && paddr == startup_oc_pkg::ADDR_STATUS) begin
      status_nxt = (status_r & ~prdata[startup_oc_pkg::EV_W-1:0]) | events;
    end else begin
      status_nxt = status_r | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & mask_r);
    end
  end
endmodule

// file: verification/current_source.sv
// Model of the current front end and breaker contact input.
// Assumes a sample every 4 cycles, four samples per rotation.
`timescale 1ns/1ns
module current_source (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] level,
  input  wire logic [15:0] ripple,
  input  wire logic        brk,
  output logic [15:0]      line_current,
  output logic             current_valid,
  output logic             rotation_mark,
  output logic             breaker_status_input
);
  logic [3:0] ph_r;
  // Ripple alternates per sample, so a window mean is exactly level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r                 <= 4'h0;
      current_valid        <= 1'b0;
      rotation_mark        <= 1'b0;
      line_current         <= 16'h0000;
      breaker_status_input <= 1'b0;
    end else begin
      ph_r                 <= ph_r + 4'h1;
      current_valid        <= ph_r[1:0] == 2'h3;
      rotation_mark        <= ph_r == 4'hf;
      line_current         <= ph_r[2] ? level + ripple : level - ripple;
      breaker_status_input <= brk;
    end
  end
endmodule

// file: verification/startup_oc_props.sv
// Port checker for the startup overcurrent element.
// Assumes one pclk domain; bound to the top module.
`timescale 1ns/1ns
module startup_oc_props #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] line_current,
  input wire logic        current_valid,
  input wire logic        rotation_mark,
  input wire logic        breaker_status_input,
  input wire logic        trip_out,
  input wire logic        irq
);
  logic [2:0] mask_r;
  logic       en_r;
  wire        wr_done = psel && penable && pready && pwrite;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow settings, so enable and mask effects can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 3'h0;
      en_r   <= 1'b0;
    end else if (wr_done && paddr == startup_oc_pkg::ADDR_MASK) begin
      mask_r <= pwdata[2:0];
    end else if (wr_done && paddr == startup_oc_pkg::ADDR_CTRL) begin
      en_r <= pwdata[0];
    end
  end
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_ans;
    pready ##1 !pready;
  endsequence
  AST_APB_WAIT: assert property (s_wait |=> s_ans)
    else $error("pready not after one wait");
  AST_UNMAPPED: assert property (pready && paddr > startup_oc_pkg::ADDR_STATE |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RESET_OUT: assert property ($rose(presetn) |-> !trip_out && !irq)
    else $error("outputs active after reset");
  AST_BRK_OFF: assert property (breaker_status_input [*6] |-> !trip_out)
    else $error("trip while breaker closed");
  AST_EN_OFF: assert property (!en_r [*5] |-> !trip_out)
    else $error("trip while disabled");
  AST_TRIP_HOLD: assert property ($rose(trip_out) |=> (trip_out || breaker_status_input || !en_r) [*8])
    else $error("trip chatter");
  AST_IRQ_TRIP: assert property ($rose(trip_out) && mask_r[2] |-> ##[0:2] irq)
    else $error("unmasked trip gave no irq");
  AST_IRQ_MASKED: assert property ((mask_r == 3'h0) [*3] |-> !irq)
    else $error("irq while all masked");
endmodule

bind startup_overcurrent_element startup_oc_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .line_current, .current_valid, .rotation_mark, .breaker_status_input, .trip_out, .irq
);

// file: verification/startup_overcurrent_element_test.sv
// Self-checking bench for the startup overcurrent element.
// Assumes the current source model and the bound port checker.
`timescale 1ns/1ns
module startup_overcurrent_element_test;
  localparam int TK = 10;
  localparam logic [11:0] CT = startup_oc_pkg::ADDR_CTRL;
  localparam logic [11:0] PK = startup_oc_pkg::ADDR_PICKUP;
  localparam logic [11:0] KO = startup_oc_pkg::ADDR_KOCT;
  localparam logic [11:0] RA = startup_oc_pkg::ADDR_RATED;
  localparam logic [11:0] SS = startup_oc_pkg::ADDR_STATUS;
  localparam logic [11:0] MK = startup_oc_pkg::ADDR_MASK;
  localparam logic [11:0] ST = startup_oc_pkg::ADDR_STATE;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] line_current, level, ripple;
  logic        current_valid, rotation_mark, breaker_status_input, trip_out, irq, brk, e;
  int          err_total, checks;
  // Reset values, then clamp cases: address, written, read back
  logic [11:0] ra [7] = '{CT, PK, KO, RA, startup_oc_pkg::ADDR_AVGCYC, SS, MK};
  logic [31:0] rv [7] = '{32'h0, 32'h00c8, 32'h0004, 32'h0064, 32'h0001, 32'h0, 32'h0};
  logic [11:0] ta [7] = '{PK, PK, PK, KO, KO, KO, startup_oc_pkg::ADDR_AVGCYC};
  logic [31:0] tw [7] = '{32'h0064, 32'h07d1, 32'h00c8, 32'h0002, 32'h00fa, 32'h0004, 32'h0000};
  logic [31:0] tx [7] = '{32'h00c8, 32'h07d0, 32'h00c8, 32'h0004, 32'h00f0, 32'h0004, 32'h0001};

  startup_overcurrent_element #(.TICK_CYCLES(TK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_current(line_current), .current_valid(current_valid), .rotation_mark(rotation_mark),
    .breaker_status_input(breaker_status_input), .trip_out(trip_out), .irq(irq)
  );
  current_source src (
    .pclk(pclk), .presetn(presetn), .level(level), .ripple(ripple), .brk(brk),
    .line_current(line_current), .current_valid(current_valid), .rotation_mark(rotation_mark),
    .breaker_status_input(breaker_status_input)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic v, input logic x);
    check({31'h0, v}, {31'h0, x});
  endtask
  // Release costs one idle edge, so back-to-back calls never double drive
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(q & m, x);
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge pclk);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, brk} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level = 16'h0000;
    ripple = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rdc(ra[i], 32'hffff_ffff, rv[i]);
    apb(1'b0, 12'h020, 32'h0);
    flag(e, 1'b1);
    check(q, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(ta[i], tw[i]);
      rdc(ta[i], 32'hffff_ffff, tx[i]);
    end
    wr(CT, 32'h0000_0004);
    level <= 16'h012c;
    ticks(850);
    flag(trip_out, 1'b0);
    rdc(ST, 32'h0020_0000, 32'h0020_0000);
    brk <= 1'b1;
    ticks(1);
    rdc(ST, 32'h0010_0000, 32'h0);
    wr(MK, 32'h0000_0004);
    wr(CT, 32'h0000_0005);
    brk <= 1'b0;
    ticks(790);
    flag(trip_out, 1'b0);
    ticks(20);
    flag(trip_out, 1'b1);
    flag(irq, 1'b1);
    rdc(SS, 32'h0000_0004, 32'h0000_0004);
    @(posedge pclk);
    flag(irq, 1'b0);
    level <= 16'h0000;
    ticks(150);
    level <= 16'h012c;
    ticks(5);
    level <= 16'h0000;
    ticks(190);
    flag(trip_out, 1'b1);
    ticks(20);
    flag(trip_out, 1'b0);
    wr(MK, 32'h0);
    wr(RA, 32'h0000_00c8);
    wr(CT, 32'h0000_0009);
    brk <= 1'b1;
    ticks(1);
    level <= 16'h0960;
    brk <= 1'b0;
    ticks(990);
    flag(trip_out, 1'b0);
    ticks(20);
    flag(trip_out, 1'b1);
    flag(irq, 1'b0);
    brk <= 1'b1;
    ticks(1);
    flag(trip_out, 1'b0);
    wr(RA, 32'h0000_0064);
    wr(CT, 32'h0000_0008);
    level <= 16'h00dc;
    brk <= 1'b0;
    ticks(1);
    rdc(ST, 32'h0020_0000, 32'h0);
    wr(CT, 32'h0);
    ticks(1);
    rdc(ST, 32'h0020_0000, 32'h0020_0000);
    wr(CT, 32'h0000_0002);
    level <= 16'h03e8;
    ripple <= 16'h0064;
    ticks(20);
    rdc(ST, 32'h0000_ffff, 32'h0000_03e8);
    summarize();
  end
endmodule
